// [logic/sideband_pkg.sv]
package sideband_pkg;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_PS = 4000;
	// Least low time on the reset pin for a full reset, in ns
	localparam int unsigned RESET_MIN_NS = 10000;
	localparam int unsigned RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Initialisation interval after reset release, in ns
	localparam int unsigned INIT_TIME_NS = 2000;
	localparam int unsigned INIT_CYC = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Samples of agreement needed before an input level is accepted
	localparam int unsigned FILTER_CYC = 4;
	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic RST_SELECT_N = 1'b1;
	localparam logic RST_RESET_N = 1'b1;
	localparam logic RST_LOW_POWER = 1'b0;
	localparam logic [7:0] RST_SETTING = 8'h00;
	// ---------------------------------------------------------------
	// Management map
	// ---------------------------------------------------------------
	// Read-only interrupt flag window, byte addresses
	localparam logic [7:0] FLAG_FIRST_BYTE = 8'h03;
	localparam logic [7:0] FLAG_LAST_BYTE = 8'h15;

	// Filtered host pins
	typedef struct packed {
		logic module_select_n;
		logic module_reset_n;
		logic low_power_request;
	} host_pins_t;

	// Open-drain pin as three signals
	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} od_pin_t;

	typedef enum logic [1:0] {ST_POWER_UP, ST_IN_RESET, ST_INIT, ST_READY} life_state_t;
endpackage

// [logic/pin_filter.sv]
`timescale 1ns/1ps
// Two-flop synchroniser followed by an agreement filter
module pin_filter import sideband_pkg::*; #(
	parameter int unsigned FILTER_LEN = FILTER_CYC,
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic pin_i,
	output logic level_o
);
	logic meta_ff;
	logic sync_ff;
	logic level_ff;
	logic [7:0] agree_ff;
	wire differs = (sync_ff != level_ff);
	wire settled = (agree_ff >= 8'(FILTER_LEN - 1));

	// ---------------------------------------------------------------
	// Synchroniser, first flop read only by the second
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			meta_ff <= RESET_VAL;
			sync_ff <= RESET_VAL;
		end else begin
			meta_ff <= pin_i;
			sync_ff <= meta_ff;
		end
	end

	// Glitches shorter than the filter never reach the output
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			agree_ff <= 8'h00;
			level_ff <= RESET_VAL;
		end else if (!differs) begin
			agree_ff <= 8'h00;
		end else if (settled) begin
			agree_ff <= 8'h00;
			level_ff <= sync_ff;
		end else begin
			agree_ff <= agree_ff + 8'h01;
		end
	end

	assign level_o = level_ff;
endmodule // pin_filter

// [logic/mgmt_gate.sv]
`timescale 1ns/1ps
// Two-wire bus gate on the serial clock domain
module mgmt_gate import sideband_pkg::*; (
	input wire logic scl_i,
	input wire logic select_n_i,
	input wire logic sda_i,
	input wire logic core_sda_oe_i,
	output logic core_sda_o,
	output logic core_enable_o,
	output logic sda_o,
	output logic sda_oe_o
);
	logic meta_ff;
	logic sync_ff;

	// ---------------------------------------------------------------
	// Select crosses into the serial clock domain as a level
	// ---------------------------------------------------------------
	// The serial clock stops between frames, so no reset edge is needed;
	// the combined gate below also uses the raw pin for an instant stop.
	always_ff @(posedge scl_i) begin
		meta_ff <= select_n_i;
		sync_ff <= meta_ff;
	end

	// Deselected: bus input looks idle and no drive is possible
	assign core_enable_o = !sync_ff && !select_n_i;
	assign core_sda_o = core_enable_o ? sda_i : 1'b1;
	assign sda_o = 1'b0;
	assign sda_oe_o = core_enable_o && core_sda_oe_i;
endmodule // mgmt_gate

// [logic/sideband_ctrl.sv]
`timescale 1ns/1ps
// Functional notes
// - With select low, the management interface accepts and answers commands.
// - With select high, all management traffic is ignored, own address too.
// - Select pin has internal pull-up; undriven means deselected.
// - Reset pin has internal pull-up; undriven means out of reset.
// - Reset low beyond minimum length restores all writable settings to defaults.
// - Initialisation timing starts at the rising edge of reset.
// - On reset completion clear not-ready bit and assert interrupt.
// - After power-up post the same completion interrupt without a reset pulse.
// - Low-power input high selects reduced-power state, else normal state.
// - Presence output low while seated, host pull-up gives high when absent.
// - Interrupt output low signals a fault or critical status.
// - Interrupt output is open-drain: pull low or release.
// - Interrupt flags sit read-only at management bytes 3 to 21.
module sideband_ctrl import sideband_pkg::*; #(
	parameter int unsigned RESET_MIN_CYCLES = RESET_MIN_CYC,
	parameter int unsigned INIT_CYCLES = INIT_CYC,
	parameter int unsigned FLAG_BYTES = 19
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic scl_i,
	input wire logic module_select_n_pin_i,
	input wire logic module_select_n_oe_i,
	input wire logic module_reset_n_pin_i,
	input wire logic module_reset_n_oe_i,
	input wire logic low_power_request_i,
	input wire logic sda_i,
	input wire logic core_sda_oe_i,
	input wire logic flag_event_i,
	input wire logic flags_read_i,
	input wire logic setting_we_i,
	input wire logic [7:0] setting_i,
	output logic core_sda_o,
	output logic core_enable_o,
	output logic sda_o,
	output logic sda_oe_o,
	output logic module_present_n_o,
	output logic module_present_n_oe_o,
	output logic module_interrupt_n_o,
	output logic module_interrupt_n_oe_o,
	output logic data_not_ready_o,
	output logic low_power_mode_o,
	output logic [7:0] setting_o,
	output logic soft_reset_o,
	output logic [1:0] state_o
);
	host_pins_t pins;
	od_pin_t irq_pin;
	life_state_t state_ff, nxt_state;
	logic [31:0] count_ff;
	logic [31:0] nxt_count;
	logic int_pending_ff;
	logic fault_ff;
	logic not_ready_ff;
	logic low_power_ff;
	logic [7:0] setting_ff;
	logic soft_reset_ff;

	// ---------------------------------------------------------------
	// Pin conditioning
	// ---------------------------------------------------------------
	// Undriven pins float to the pulled-up level
	wire select_n_raw = module_select_n_oe_i ? module_select_n_pin_i : 1'b1;
	wire reset_n_raw = module_reset_n_oe_i ? module_reset_n_pin_i : 1'b1;

	// Each host pin is synchronised and filtered; the bus gate below takes select raw
	pin_filter #(.FILTER_LEN(FILTER_CYC), .RESET_VAL(RST_SELECT_N)) u_sel (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pin_i(select_n_raw),
		.level_o(pins.module_select_n)
	);
	pin_filter #(.FILTER_LEN(FILTER_CYC), .RESET_VAL(RST_RESET_N)) u_rst (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pin_i(reset_n_raw),
		.level_o(pins.module_reset_n)
	);
	pin_filter #(.FILTER_LEN(FILTER_CYC), .RESET_VAL(RST_LOW_POWER)) u_lp (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.pin_i(low_power_request_i),
		.level_o(pins.low_power_request)
	);

	// ---------------------------------------------------------------
	// Management bus gate, on the serial clock
	// ---------------------------------------------------------------
	// Raw select used here: bus gating must not lag behind the filter
	mgmt_gate u_gate (
		.scl_i(scl_i),
		.select_n_i(select_n_raw),
		.sda_i(sda_i),
		.core_sda_oe_i(core_sda_oe_i),
		.core_sda_o(core_sda_o),
		.core_enable_o(core_enable_o),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o)
	);

	// ---------------------------------------------------------------
	// Lifecycle decode
	// ---------------------------------------------------------------
	wire reset_low = !pins.module_reset_n;
	wire reset_long = reset_low && (count_ff >= RESET_MIN_CYCLES - 1);
	wire init_done = (count_ff >= INIT_CYCLES - 1);

	always_comb begin
		nxt_state = state_ff;
		nxt_count = count_ff;
		unique case (state_ff)
			ST_POWER_UP: begin
				// Power-up runs the initialisation without any pulse
				nxt_state = ST_INIT;
				nxt_count = 32'h0;
			end
			ST_READY, ST_INIT: begin
				if (reset_low) begin
					nxt_count = count_ff + 32'h1;
					if (reset_long) begin
						nxt_state = ST_IN_RESET;
						nxt_count = 32'h0;
					end
				end else if (state_ff == ST_INIT) begin
					nxt_count = init_done ? 32'h0 : count_ff + 32'h1;
					if (init_done) begin
						nxt_state = ST_READY;
					end
				end else begin
					// Short pulse discarded
					nxt_count = 32'h0;
				end
			end
			ST_IN_RESET: begin
				// Timing starts at the release edge
				if (!reset_low) begin
					nxt_state = ST_INIT;
					nxt_count = 32'h0;
				end
			end
		endcase
	end

	// Short-pulse timer shares the counter with the init timer; a pulse
	// during init keeps the count running, so its cycles shorten the init time.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= ST_POWER_UP;
			count_ff <= 32'h0;
		end else begin
			state_ff <= nxt_state;
			count_ff <= nxt_count;
		end
	end

	// ---------------------------------------------------------------
	// Status and settings
	// ---------------------------------------------------------------
	wire entering_ready = (state_ff == ST_INIT) && (nxt_state == ST_READY);
	wire in_reset = (state_ff == ST_IN_RESET);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			not_ready_ff <= 1'b1;
		end else if (in_reset) begin
			not_ready_ff <= 1'b1;
		end else if (entering_ready) begin
			not_ready_ff <= 1'b0;
		end
	end

	// Writable settings back to defaults on a full reset
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			setting_ff <= RST_SETTING;
		end else if (in_reset) begin
			setting_ff <= RST_SETTING;
		end else if (setting_we_i && state_ff == ST_READY) begin
			setting_ff <= setting_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			soft_reset_ff <= 1'b1;
			low_power_ff <= RST_LOW_POWER;
		end else begin
			soft_reset_ff <= in_reset;
			low_power_ff <= pins.low_power_request;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt
	// ---------------------------------------------------------------
	// Pending completion or fault; a new event beats a read in the same cycle
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			int_pending_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else if (in_reset) begin
			int_pending_ff <= 1'b0;
			fault_ff <= 1'b0;
		end else begin
			if (entering_ready) begin
				int_pending_ff <= 1'b1;
			end else if (flags_read_i) begin
				int_pending_ff <= 1'b0;
			end
			if (flag_event_i && state_ff == ST_READY) begin
				fault_ff <= 1'b1;
			end else if (flags_read_i) begin
				fault_ff <= 1'b0;
			end
		end
	end

	// Open drain: drive low or release, never drive high
	assign irq_pin.out = 1'b0;
	assign irq_pin.oe = (int_pending_ff || fault_ff) && (state_ff == ST_READY);
	assign irq_pin.in = 1'b0;

	assign module_interrupt_n_o = irq_pin.out;
	assign module_interrupt_n_oe_o = irq_pin.oe;
	// Presence is a ground strap inside the module
	assign module_present_n_o = 1'b0;
	assign module_present_n_oe_o = 1'b1;
	assign data_not_ready_o = not_ready_ff;
	assign low_power_mode_o = low_power_ff;
	assign setting_o = setting_ff;
	assign soft_reset_o = soft_reset_ff;
	assign state_o = state_ff;

	// ---------------------------------------------------------------
	// Interrupt flag map
	// ---------------------------------------------------------------
	// Flag bytes are a fixed read-only window of the management map; the
	// buffer size must match it or the host's one-shot read comes up short.
	localparam int unsigned FLAG_SPAN = int'(FLAG_LAST_BYTE) - int'(FLAG_FIRST_BYTE) + 1;
	wire flag_map_ok = (FLAG_BYTES == FLAG_SPAN);
	// Nothing but an event, a host read or a lifecycle step moves the flags
	wire flags_quiet = !flag_event_i && !flags_read_i && !entering_ready && !in_reset;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence s_release;
		$rose(pins.module_reset_n) && state_ff == ST_IN_RESET;
	endsequence

	a_init_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_release |=> state_ff == ST_INIT && count_ff == 32'h0)
		else $error("init did not start at reset release");
	a_irq_in_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff != ST_READY |-> !module_interrupt_n_oe_o)
		else $error("interrupt driven before ready");
	a_ready_irq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		entering_ready |=> module_interrupt_n_oe_o && !data_not_ready_o)
		else $error("completion not announced");
	a_power_up: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff == ST_POWER_UP |=> state_ff == ST_INIT)
		else $error("power-up did not start init");
	a_defaults: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		in_reset |=> setting_ff == RST_SETTING)
		else $error("settings not restored");
	a_od_low: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		module_interrupt_n_o == 1'b0)
		else $error("interrupt pin driven high");
	a_deselect: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		select_n_raw |-> !sda_oe_o && core_sda_o)
		else $error("traffic passed while deselected");
	a_low_power: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		$changed(pins.low_power_request) |=> low_power_mode_o == $past(pins.low_power_request))
		else $error("low power not followed");
	a_presence: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!module_present_n_o && module_present_n_oe_o)
		else $error("presence not low");

	// Fault raised while running, with no full reset about to start
	sequence s_event_ready;
		flag_event_i && state_ff == ST_READY && !reset_long;
	endsequence

	// Host read with nothing new to report in the same cycle
	sequence s_clean_read;
		flags_read_i && !flag_event_i && !entering_ready && !in_reset;
	endsequence

	// Reset pin held past the minimum while running or initialising
	sequence s_long_pulse;
		reset_long && (state_ff == ST_READY || state_ff == ST_INIT);
	endsequence

	// Interrupt line: set beats clear, clear releases, nothing but a read or a long reset drops it
	a_event_wins: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_event_ready |=> module_interrupt_n_oe_o)
		else $error("fault event lost");
	a_read_clears: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_clean_read |=> !module_interrupt_n_oe_o)
		else $error("interrupt line not released");
	a_irq_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		module_interrupt_n_oe_o && !flags_read_i && !reset_long |=> module_interrupt_n_oe_o)
		else $error("interrupt dropped without a read");
	a_flags_ro: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		flags_quiet |=> $stable(fault_ff) && $stable(int_pending_ff))
		else $error("flags moved without cause");
	a_flag_map: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		flag_map_ok)
		else $error("flag buffer size differs from map");

	// Lifecycle: long pulses reset, short ones do not while ready, init runs its length
	a_long_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		s_long_pulse |=> state_ff == ST_IN_RESET ##1 soft_reset_o)
		else $error("long reset pulse not taken");
	a_soft_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff == ST_READY |=> !soft_reset_o)
		else $error("soft reset shown while ready");
	a_short_pulse: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff == ST_READY && !reset_long |=> state_ff == ST_READY)
		else $error("ready left without a long pulse");
	a_held_reset: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff == ST_IN_RESET && reset_low |=> state_ff == ST_IN_RESET)
		else $error("init started before release");
	a_init_busy: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff == ST_INIT |-> data_not_ready_o)
		else $error("ready flagged during init");
	a_no_early_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff == ST_INIT && !init_done |=> state_ff != ST_READY)
		else $error("init cut short");
	a_init_ends: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		state_ff == ST_INIT && init_done && !reset_low |=> state_ff == ST_READY)
		else $error("init never completed");

	// Settings and bus gate
	a_writes_ready: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		!in_reset && !(setting_we_i && state_ff == ST_READY) |=> $stable(setting_ff))
		else $error("setting changed outside a write");
	a_select_pass: assert property (@(posedge clk_i) disable iff (!reset_n_i)
		core_enable_o |-> core_sda_o == sda_i && sda_oe_o == core_sda_oe_i)
		else $error("selected bus not passed through");
endmodule // sideband_ctrl

// [tb/host_model.sv]
`timescale 1ns/1ps
// Host board model: drives select, reset and serial clock, supplies the pull-ups
module host_model (
	input wire logic sel_drive_i,
	input wire logic sel_level_i,
	input wire logic rst_drive_i,
	input wire logic rst_level_i,
	input wire logic frame_i,
	input wire logic host_sda_low_i,
	input wire logic dev_sda_i,
	input wire logic dev_sda_oe_i,
	input wire logic irq_i,
	input wire logic irq_oe_i,
	input wire logic present_i,
	input wire logic present_oe_i,
	output logic sel_pin_o,
	output logic sel_oe_o,
	output logic rst_pin_o,
	output logic rst_oe_o,
	output logic scl_o,
	output logic sda_o,
	output logic irq_line_o,
	output logic present_line_o
);
	logic scl_ff;
	// ---------------------------------------------------------------
	// Host pin drivers
	// ---------------------------------------------------------------
	// Released pins show the inverse level, so a device that trusts them is caught
	assign sel_oe_o = sel_drive_i;
	assign sel_pin_o = sel_drive_i ? sel_level_i : ~sel_level_i;
	assign rst_oe_o = rst_drive_i;
	assign rst_pin_o = rst_drive_i ? rst_level_i : ~rst_level_i;
	// ---------------------------------------------------------------
	// Shared lines with host pull-ups
	// ---------------------------------------------------------------
	assign sda_o = !(host_sda_low_i || (dev_sda_oe_i && !dev_sda_i));
	assign irq_line_o = !(irq_oe_i && !irq_i);
	assign present_line_o = !(present_oe_i && !present_i);
	// Serial clock runs only inside frames, idles high between them
	initial begin
		scl_ff = 1'b1;
		#13;
		forever begin
			#40;
			scl_ff = frame_i ? ~scl_ff : 1'b1;
		end
	end
	assign scl_o = scl_ff;
endmodule // host_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	n_mismatch++; $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module tb_top import sideband_pkg::*; ;
	logic clk_i, reset_n_i, lp, flag_ev, flags_rd, set_we, frame, host_sda_low, core_sda_oe;
	logic sel_drive, sel_level, rst_drive, rst_level;
	logic [7:0] set_val;
	wire logic scl, sel_pin, sel_oe, rst_pin, rst_oe, sda, core_sda, core_en, dsda, dsda_oe;
	wire logic pres, pres_oe, irq, irq_oe, nrdy, lpm, soft_rst, irq_line, pres_line;
	wire logic [7:0] set_o;
	wire logic [1:0] st;
	int n_mismatch = 0;
	int comparisons = 0;
	int n;
	// ---------------------------------------------------------------
	// Design and host board
	// ---------------------------------------------------------------
	sideband_ctrl #(.RESET_MIN_CYCLES(8), .INIT_CYCLES(16)) u_dut (.clk_i(clk_i),
		.reset_n_i(reset_n_i), .scl_i(scl), .module_select_n_pin_i(sel_pin),
		.module_select_n_oe_i(sel_oe), .module_reset_n_pin_i(rst_pin),
		.module_reset_n_oe_i(rst_oe), .low_power_request_i(lp), .sda_i(sda),
		.core_sda_oe_i(core_sda_oe), .flag_event_i(flag_ev), .flags_read_i(flags_rd),
		.setting_we_i(set_we), .setting_i(set_val), .core_sda_o(core_sda),
		.core_enable_o(core_en), .sda_o(dsda), .sda_oe_o(dsda_oe), .module_present_n_o(pres),
		.module_present_n_oe_o(pres_oe), .module_interrupt_n_o(irq),
		.module_interrupt_n_oe_o(irq_oe), .data_not_ready_o(nrdy), .low_power_mode_o(lpm),
		.setting_o(set_o), .soft_reset_o(soft_rst), .state_o(st));
	host_model u_host (.sel_drive_i(sel_drive), .sel_level_i(sel_level),
		.rst_drive_i(rst_drive), .rst_level_i(rst_level), .frame_i(frame),
		.host_sda_low_i(host_sda_low), .dev_sda_i(dsda), .dev_sda_oe_i(dsda_oe), .irq_i(irq),
		.irq_oe_i(irq_oe), .present_i(pres), .present_oe_i(pres_oe), .sel_pin_o(sel_pin),
		.sel_oe_o(sel_oe), .rst_pin_o(rst_pin), .rst_oe_o(rst_oe), .scl_o(scl), .sda_o(sda),
		.irq_line_o(irq_line), .present_line_o(pres_line));
	// Core clock, 4 ns
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	// Inputs always move 1 ns after the rising edge
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	// Bounded wait for a life state, returns cycles spent
	task automatic wait_st(input logic [1:0] s, input int lim, output int k);
		k = 0;
		while (st !== s && k < lim) begin
			cyc(1);
			k++;
		end
		`CHK("state", s, st)
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Hang guard, far beyond the ~380 cycles the tests need
	initial begin
		#20000;
		n_mismatch++;
		$display("watchdog expired");
		conclude();
	end
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial begin
		{reset_n_i, lp, flag_ev, flags_rd, set_we, frame, host_sda_low, core_sda_oe} = '0;
		{sel_drive, sel_level, rst_drive, rst_level} = 4'b0111;
		set_val = 8'h00;
		repeat (2) @(posedge clk_i);
		#1 reset_n_i = 1'b1;
		`CHK("irq_line", 1'b1, irq_line)
		cyc(1);
		`CHK("state", ST_INIT, st)
		cyc(15);
		`CHK("irq_line", 1'b1, irq_line)
		`CHK("not_ready", 1'b1, nrdy)
		cyc(1);
		`CHK("state", ST_READY, st)
		`CHK("irq_line", 1'b0, irq_line)
		`CHK("not_ready", 1'b0, nrdy)
		`CHK("present", 1'b0, pres_line)
		$display("test power_up done");
		// Read clears, event sets, event wins over a read in the same cycle
		flags_rd = 1'b1;
		cyc(1);
		flags_rd = 1'b0;
		`CHK("irq_line", 1'b1, irq_line)
		flag_ev = 1'b1;
		cyc(1);
		flag_ev = 1'b0;
		cyc(1);
		`CHK("irq_line", 1'b0, irq_line)
		{flag_ev, flags_rd} = 2'b11;
		cyc(1);
		{flag_ev, flags_rd} = 2'b00;
		cyc(1);
		`CHK("irq_line", 1'b0, irq_line)
		flags_rd = 1'b1;
		cyc(1);
		flags_rd = 1'b0;
		`CHK("irq_line", 1'b1, irq_line)
		$display("test interrupt done");
		// Setting survives a short pulse and a released pin, not a long pulse
		{set_we, set_val} = {1'b1, 8'h5a};
		cyc(1);
		set_we = 1'b0;
		cyc(1);
		`CHK("setting", 8'h5a, set_o)
		rst_level = 1'b0;
		cyc(4);
		rst_level = 1'b1;
		cyc(30);
		`CHK("state", ST_READY, st)
		`CHK("setting", 8'h5a, set_o)
		rst_drive = 1'b0;
		cyc(40);
		`CHK("state", ST_READY, st)
		{rst_drive, rst_level} = 2'b10;
		wait_st(ST_IN_RESET, 40, n);
		// Soft reset is registered from the state, one cycle behind it
		cyc(1);
		`CHK("soft_reset", 1'b1, soft_rst)
		{set_we, set_val} = {1'b1, 8'hc3};
		cyc(20);
		set_we = 1'b0;
		`CHK("setting", 8'h00, set_o)
		`CHK("irq_line", 1'b1, irq_line)
		rst_level = 1'b1;
		wait_st(ST_INIT, 20, n);
		`CHK("not_ready", 1'b1, nrdy)
		wait_st(ST_READY, 40, n);
		`CHK("init_cycles", 16, n)
		`CHK("irq_line", 1'b0, irq_line)
		`CHK("not_ready", 1'b0, nrdy)
		$display("test reset done");
		// Select gating of the management bus with the serial clock running
		{frame, host_sda_low, core_sda_oe} = 3'b111;
		cyc(60);
		`CHK("core_enable", 1'b0, core_en)
		`CHK("core_sda", 1'b1, core_sda)
		`CHK("sda_line", 1'b0, sda)
		host_sda_low = 1'b0;
		cyc(2);
		`CHK("sda_line", 1'b1, sda)
		{sel_drive, sel_level} = 2'b10;
		cyc(60);
		`CHK("core_enable", 1'b1, core_en)
		`CHK("sda_line", 1'b0, sda)
		{host_sda_low, core_sda_oe} = 2'b10;
		cyc(2);
		`CHK("core_sda", 1'b0, core_sda)
		sel_level = 1'b1;
		cyc(60);
		`CHK("core_enable", 1'b0, core_en)
		`CHK("core_sda", 1'b1, core_sda)
		{frame, host_sda_low} = 2'b00;
		$display("test select done");
		// Low-power request follows the pin after filtering
		lp = 1'b1;
		cyc(20);
		`CHK("low_power", 1'b1, lpm)
		lp = 1'b0;
		cyc(20);
		`CHK("low_power", 1'b0, lpm)
		$display("test low_power done");
		conclude();
	end
endmodule // tb_top
